//--- rtl/pwc_pkg.sv
package pwc_pkg;

    // =========================================================
    // register map (byte addresses)
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_CTRL_RMW  = 8'h04;
    localparam logic [7:0]  OFS_RESULT    = 8'h08;
    localparam logic [7:0]  OFS_DIV       = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_ST    = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h14;

    // =========================================================
    // control/status bit positions (bits 7..0 hold pwc_cfg_t)
    localparam int B_PULSE_LEVEL_INDICATOR    = 8;
    localparam int B_OVF     = 9;
    localparam int B_OVF_EN  = 10;
    localparam int B_END     = 11;
    localparam int B_END_EN  = 12;
    localparam int B_ERR     = 13;
    localparam int B_STOP    = 14;
    localparam int B_START   = 15;

    // =========================================================
    // operating mode / edge select codes
    localparam logic [2:0]  MODE_ONESHOT  = 3'h0;
    localparam logic [2:0]  MODE_RELOAD   = 3'h1;
    localparam logic [2:0]  MODE_EDGE     = 3'h2;
    localparam logic [2:0]  MODE_DIV      = 3'h3;
    localparam logic [2:0]  MODE_RISE     = 3'h4;
    localparam logic [2:0]  MODE_HIGH     = 3'h5;
    localparam logic [2:0]  MODE_LOW      = 3'h6;
    localparam logic [2:0]  MODE_FALL     = 3'h7;

    // =========================================================
    // reset values and constants
    localparam logic [7:0]  CFG_RST       = 8'h00;
    localparam logic [1:0]  DIV_RST       = 2'h0;
    localparam logic [2:0]  IRQ_RST       = 3'h0;
    localparam logic [15:0] CNT_ZERO      = 16'h0000;
    localparam logic [15:0] CNT_MAX       = 16'hffff;
    localparam logic [8:0]  DIV_BASE      = 9'h004;
    localparam logic [8:0]  DIV_ONE       = 9'h001;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [1:0]  RMW_START_STOP = 2'h3;

    // prescaler masks: machine clock /4, /16, /32
    localparam int          PS_W          = 5;
    localparam logic [4:0]  PS_MASK_4     = 5'h03;
    localparam logic [4:0]  PS_MASK_16    = 5'h0f;
    localparam logic [4:0]  PS_MASK_32    = 5'h1f;
    localparam logic [4:0]  PS_ZERO       = 5'h00;

    // =========================================================
    // types
    typedef struct packed {
        logic [1:0] clk_sel;
        logic [1:0] pin_sel;
        logic       continuous;
        logic [2:0] mode;
    } pwc_cfg_t;

    typedef struct packed {
        logic err;
        logic cnt_end;
        logic ovf;
    } pwc_evt_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_WAIT  = 4'h2,
        ST_COUNT = 4'h4,
        ST_TIMER = 4'h8
    } pwc_state_t;

endpackage : pwc_pkg

//--- rtl/pwc_prescaler.sv
`timescale 1ns/1ps

module pwc_prescaler
    import pwc_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             clear,
    input  wire logic [1:0]       clk_sel,
    output logic                  tick
);

    logic [PS_W-1:0] ps_ff;
    logic [PS_W-1:0] mask;
    logic            tick_ff;

    // =========================================================
    // divider select
    assign mask = (clk_sel == 2'h0) ? PS_MASK_4 :
                  (clk_sel == 2'h1) ? PS_MASK_16 : PS_MASK_32;
    assign tick = tick_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            ps_ff   <= PS_ZERO;
            tick_ff <= 1'b0;
        end else begin
            ps_ff   <= ps_ff + 5'h01;
            tick_ff <= ((ps_ff & mask) == mask);
        end
    end

endmodule : pwc_prescaler

//--- rtl/pwc_timer.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps

module pwc_timer
    import pwc_pkg::*;
#(
    parameter int CHANNELS = 4
)
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [7:0]          awaddr,
    input  wire logic [2:0]          awprot,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [7:0]          araddr,
    input  wire logic [2:0]          arprot,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    input  wire logic [CHANNELS-1:0] count_in,
    output logic                     pulse_level_indicator,
    output logic                     irq
);

    // =========================================================
    // state
    pwc_state_t     state_ff,   nxt_state;
    logic [15:0]    counter_ff, nxt_counter;
    logic [15:0]    reload_ff;
    logic [15:0]    result_ff;
    pwc_cfg_t       cfg_ff;
    logic [1:0]     input_divide_ratio_ff;
    logic [7:0]     div_cnt_ff;
    logic           pulse_level_indicator_ff;
    logic           overflow_flag_ff;
    logic           ovf_en_ff;
    logic           count_end_flag_ff;
    logic           count_end_irq_enable_ff;
    logic           err_flag_ff;
    logic           unread_ff;
    logic           in_prev_ff;
    logic [2:0]     irq_st_ff;
    logic [2:0]     irq_mask_ff;

    // bus side
    logic           aw_have_ff;
    logic           w_have_ff;
    logic [7:0]     awaddr_ff;
    logic [31:0]    wdata_ff;
    logic [3:0]     wstrb_ff;
    logic           bvalid_ff;
    logic [1:0]     bresp_ff;
    logic           rvalid_ff;
    logic [1:0]     rresp_ff;
    logic [31:0]    rdata_ff;

    // =========================================================
    // axi4-lite write channel
    wire wr_fire   = aw_have_ff && w_have_ff && !bvalid_ff;
    wire wr_lo     = wstrb_ff[0];
    wire wr_hi     = wstrb_ff[1];
    wire wr_ctrl   = wr_fire && ((awaddr_ff == OFS_CTRL) || (awaddr_ff == OFS_CTRL_RMW));
    wire wr_result = wr_fire && (awaddr_ff == OFS_RESULT);
    wire wr_div    = wr_fire && (awaddr_ff == OFS_DIV) && wr_lo;
    wire wr_mask   = wr_fire && (awaddr_ff == OFS_IRQ_MASK) && wr_lo;
    wire wr_hit    = (awaddr_ff == OFS_CTRL) || (awaddr_ff == OFS_CTRL_RMW) ||
                     (awaddr_ff == OFS_RESULT) || (awaddr_ff == OFS_DIV) ||
                     (awaddr_ff == OFS_IRQ_ST) || (awaddr_ff == OFS_IRQ_MASK);

    assign awready = !aw_have_ff && !bvalid_ff;
    assign wready  = !w_have_ff && !bvalid_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            awaddr_ff  <= 8'h00;
        end else if (awvalid && awready) begin
            aw_have_ff <= 1'b1;
            awaddr_ff  <= awaddr;
        end else if (wr_fire) begin
            aw_have_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_ff <= 1'b0;
            wdata_ff  <= 32'h00000000;
            wstrb_ff  <= 4'h0;
        end else if (wvalid && wready) begin
            w_have_ff <= 1'b1;
            wdata_ff  <= wdata;
            wstrb_ff  <= wstrb;
        end else if (wr_fire) begin
            w_have_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // control write strobes
    // start stop writes
    wire start_cmd = wr_ctrl && wr_hi && wdata_ff[B_START] && !wdata_ff[B_STOP];
    wire stop_cmd  = wr_ctrl && wr_hi && wdata_ff[B_STOP];

    // =========================================================
    // axi4-lite read channel
    wire rd_fire   = arvalid && arready;
    wire rd_result = rd_fire && (araddr == OFS_RESULT);
    wire rd_irq_st = rd_fire && (araddr == OFS_IRQ_ST);
    wire running   = (state_ff != ST_IDLE);
    wire cont_pwc  = cfg_ff.continuous && cfg_ff.mode[2:1] != 2'h0;

    wire [13:0] ctrl_low = {err_flag_ff, count_end_irq_enable_ff, count_end_flag_ff,
                            ovf_en_ff, overflow_flag_ff, pulse_level_indicator_ff, cfg_ff};
    wire [31:0] rd_ctrl  = {16'h0000, running, 1'b0, ctrl_low};
    wire [31:0] rd_rmw   = {16'h0000, RMW_START_STOP, ctrl_low};
    wire [15:0] rd_res16 = cont_pwc ? result_ff : counter_ff;

    wire [31:0] rd_data  =
        (araddr == OFS_CTRL)     ? rd_ctrl :
        (araddr == OFS_CTRL_RMW) ? rd_rmw :
        (araddr == OFS_RESULT)   ? {16'h0000, rd_res16} :
        (araddr == OFS_DIV)      ? {30'h00000000, input_divide_ratio_ff} :
        (araddr == OFS_IRQ_ST)   ? {29'h00000000, irq_st_ff} :
        (araddr == OFS_IRQ_MASK) ? {29'h00000000, irq_mask_ff} : 32'h00000000;
    wire rd_hit = (araddr == OFS_CTRL) || (araddr == OFS_CTRL_RMW) ||
                  (araddr == OFS_RESULT) || (araddr == OFS_DIV) ||
                  (araddr == OFS_IRQ_ST) || (araddr == OFS_IRQ_MASK);

    assign arready = !rvalid_ff;
    assign rvalid  = rvalid_ff;
    assign rresp   = rresp_ff;
    assign rdata   = rdata_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= RESP_OKAY;
            rdata_ff  <= 32'h00000000;
        end else if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_ff  <= rd_data;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // =========================================================
    // input edge detection and mode decode
    wire in_sel     = count_in[cfg_ff.pin_sel];
    wire rise       = in_sel && !in_prev_ff;
    wire fall       = !in_sel && in_prev_ff;
    wire timer_mode = (cfg_ff.mode[2:1] == 2'h0);
    wire m          = 1'b0;
    // a start written together with a new mode follows the new mode
    pwc_cfg_t wr_cfg;
    assign wr_cfg = pwc_cfg_t'(wdata_ff[7:0]);
    wire start_tmr  = (wr_ctrl && wr_lo) ? (wr_cfg.mode[2:1] == 2'h0) : timer_mode;
    wire [8:0] ratio    = DIV_BASE << {input_divide_ratio_ff, 1'b0};
    wire [7:0] ratio_m1 = 8'(ratio - DIV_ONE);
    wire div_done   = fall && (div_cnt_ff == ratio_m1);

    wire start_edge = (cfg_ff.mode == MODE_HIGH || cfg_ff.mode == MODE_RISE) ? rise :
                      (cfg_ff.mode == MODE_LOW || cfg_ff.mode == MODE_FALL ||
                       cfg_ff.mode == MODE_DIV) ? fall :
                      (cfg_ff.mode == MODE_EDGE) ? (rise | fall) : m;
    wire end_sel    = (cfg_ff.mode == MODE_HIGH || cfg_ff.mode == MODE_FALL) ? fall :
                      (cfg_ff.mode == MODE_LOW || cfg_ff.mode == MODE_RISE) ? rise :
                      (cfg_ff.mode == MODE_EDGE) ? (rise | fall) :
                      (cfg_ff.mode == MODE_DIV) ? div_done : m;
    // end edge doubles as next start edge in period and inter-edge modes
    wire chain      = cfg_ff.continuous && cfg_ff.mode != MODE_HIGH &&
                      cfg_ff.mode != MODE_LOW;

    logic tick;
    wire start_hit = (state_ff == ST_WAIT) && start_edge;
    wire end_evt   = (state_ff == ST_COUNT) && end_sel;
    wire store     = end_evt && cfg_ff.continuous;
    wire ovf_evt   = tick && (counter_ff == CNT_MAX) &&
                     (state_ff == ST_COUNT || state_ff == ST_TIMER);

    wire ps_clear  = start_cmd || (start_hit && !cfg_ff.continuous);

    pwc_prescaler u_prescaler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear   (ps_clear),
        .clk_sel (cfg_ff.clk_sel),
        .tick    (tick)
    );

    // =========================================================
    // counting state machine
    always_comb begin
        nxt_state   = state_ff;
        nxt_counter = counter_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_state = ST_IDLE;
            end
            ST_WAIT: begin
                if (start_edge) begin
                    nxt_state   = ST_COUNT;
                    nxt_counter = CNT_ZERO;
                end
            end
            ST_COUNT: begin
                if (end_sel) begin
                    nxt_state   = !cfg_ff.continuous ? ST_IDLE : chain ? ST_COUNT : ST_WAIT;
                    nxt_counter = chain ? CNT_ZERO : counter_ff;
                end else if (tick) begin
                    nxt_counter = counter_ff + 16'h0001;
                end
            end
            ST_TIMER: begin
                if (tick) begin
                    nxt_counter = counter_ff + 16'h0001;
                    if (counter_ff == CNT_MAX) begin
                        nxt_counter = (cfg_ff.mode == MODE_RELOAD) ? reload_ff : CNT_ZERO;
                        nxt_state   = (cfg_ff.mode == MODE_RELOAD) ? ST_TIMER : ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (wr_result && wr_lo) begin
            nxt_counter[7:0] = wdata_ff[7:0];
        end
        if (wr_result && wr_hi) begin
            nxt_counter[15:8] = wdata_ff[15:8];
        end
        if (start_cmd) begin
            nxt_state   = start_tmr ? ST_TIMER : ST_WAIT;
            nxt_counter = start_tmr ? reload_ff : nxt_counter;
        end
        if (stop_cmd) begin
            nxt_state = ST_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff   <= ST_IDLE;
            counter_ff <= CNT_ZERO;
            in_prev_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            counter_ff <= nxt_counter;
            in_prev_ff <= in_sel;
        end
    end

    // divided period edge counter
    always_ff @(posedge aclk) begin
        if (!aresetn || start_cmd || start_hit || (end_evt && chain)) begin
            div_cnt_ff <= 8'h00;
        end else if (state_ff == ST_COUNT && fall) begin
            div_cnt_ff <= div_cnt_ff + 8'h01;
        end
    end

    // =========================================================
    // software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_ff                <= CFG_RST;
            input_divide_ratio_ff <= DIV_RST;
            irq_mask_ff           <= IRQ_RST;
            ovf_en_ff             <= 1'b0;
            count_end_irq_enable_ff <= 1'b0;
        end else begin
            if (wr_ctrl && wr_lo) begin
                cfg_ff <= pwc_cfg_t'(wdata_ff[7:0]);
            end
            if (wr_ctrl && wr_hi) begin
                ovf_en_ff               <= wdata_ff[B_OVF_EN];
                count_end_irq_enable_ff <= wdata_ff[B_END_EN];
            end
            if (wr_div) begin
                input_divide_ratio_ff <= wdata_ff[1:0];
            end
            if (wr_mask) begin
                irq_mask_ff <= wdata_ff[2:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_ff <= CNT_ZERO;
        end else begin
            if (wr_result && wr_lo) begin
                reload_ff[7:0] <= wdata_ff[7:0];
            end
            if (wr_result && wr_hi) begin
                reload_ff[15:8] <= wdata_ff[15:8];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_ff <= CNT_ZERO;
        end else if (store) begin
            result_ff <= counter_ff;
        end
    end

    // =========================================================
    // flags: hardware set wins over clear
    wire ovf_clr = wr_ctrl && wr_hi && !wdata_ff[B_OVF];
    wire end_clr = wr_ctrl && wr_hi && !wdata_ff[B_END];
    wire err_set = store && unread_ff && !rd_result;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag_ff  <= 1'b0;
            count_end_flag_ff <= 1'b0;
            err_flag_ff       <= 1'b0;
            unread_ff         <= 1'b0;
        end else begin
            overflow_flag_ff  <= ovf_evt || (overflow_flag_ff && !ovf_clr);
            count_end_flag_ff <= end_evt || (count_end_flag_ff && !end_clr && !rd_result);
            err_flag_ff       <= err_set || (err_flag_ff && !rd_result);
            unread_ff         <= store || (unread_ff && !rd_result);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_level_indicator_ff <= 1'b0;
        end else if (ovf_evt && state_ff == ST_TIMER) begin
            pulse_level_indicator_ff <= !pulse_level_indicator_ff;
        end else if (wr_ctrl && wr_hi && !running) begin
            pulse_level_indicator_ff <= wdata_ff[B_PULSE_LEVEL_INDICATOR];
        end
    end

    assign pulse_level_indicator = pulse_level_indicator_ff;

    // =========================================================
    // interrupt status, read clears, set wins
    pwc_evt_t evt;
    assign evt.ovf     = ovf_evt && ovf_en_ff;
    assign evt.cnt_end = end_evt && count_end_irq_enable_ff;
    assign evt.err     = err_set && count_end_irq_enable_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_st_ff <= IRQ_RST;
        end else begin
            irq_st_ff <= (irq_st_ff & {3{!rd_irq_st}}) | evt;
        end
    end

    assign irq = |(irq_st_ff & irq_mask_ff);

endmodule : pwc_timer

//--- bench/pwc_props.sv
`timescale 1ns/1ps

module pwc_props
    import pwc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [7:0]  araddr,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp
);
    // =========================================================
    // bus answer timing
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence wr_take_s;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence wr_answer_s;
        !bvalid ##1 bvalid;
    endsequence
    sequence rd_take_s;
        arvalid && arready;
    endsequence

    write_answer_a: assert property (wr_take_s |=> wr_answer_s)
        else $error("write answer not two cycles after taking");
    read_answer_a: assert property (rd_take_s |=> rvalid)
        else $error("read answer not one cycle after taking");
    bresp_drop_a: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer held after acceptance");
    rresp_drop_a: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer held after acceptance");
    wr_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write channel open while answer pending");
    rd_block_a: assert property (rvalid |-> !arready)
        else $error("read channel open while answer pending");
    rmw_view_a: assert property (
        rd_take_s and araddr == OFS_CTRL_RMW |=> rdata[15:14] == RMW_START_STOP)
        else $error("rmw view does not show start and stop set");
    unmapped_rd_a: assert property (
        rd_take_s and araddr == 8'h18 |=> rresp == RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule : pwc_props

//--- bench/pwc_pulse_src.sv
`timescale 1ns/1ps

module pwc_pulse_src
(
    input  wire logic       aclk,
    output logic      [3:0] pin
);
    // unselected pins rest low as if pulled down
    initial begin
        pin = 4'h0;
    end

    task automatic pulse(input int hi, input int lo);
        @(posedge aclk);
        pin[0] <= 1'b1;
        repeat ((hi < 2) ? 2 : hi) @(posedge aclk);
        pin[0] <= 1'b0;
        repeat ((lo < 2) ? 2 : lo) @(posedge aclk);
    endtask : pulse
endmodule : pwc_pulse_src

//--- bench/test_pulse_width_counter_timer.sv
`timescale 1ns/1ps

module test_pulse_width_counter_timer
    import pwc_pkg::*;
;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq, pulse_level_indicator;
    logic [7:0]  awaddr, araddr;
    logic [2:0]  awprot, arprot;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb, count_in;
    logic [1:0]  bresp, rresp, rs, bs;
    int          fails;
    int          checks_done;

    pwc_timer #(.CHANNELS(4)) DUT (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .count_in,
        .pulse_level_indicator, .irq);
    pwc_pulse_src u_src (.aclk(aclk), .pin(count_in));

    // =========================================================
    // report and compare
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic over;
        fails++;
        $display("MISMATCH t=%0t wait ran out", $time);
        tally_and_finish();
    endtask : over

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        checks_done++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            fails++;
            $display("MISMATCH t=%0t got %h range %h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng

    // =========================================================
    // bus cycles
    task automatic axw(input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (n > 40) over();
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            bs = bresp;
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (n > 40) over();
            if (arvalid && arready) arvalid <= 1'b0;
            rd = rdata;
            rs = rresp;
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask : axr

    // =========================================================
    // scenarios
    task automatic t_reset;
        axr(OFS_CTRL);
        chk(rd[15:0], 16'h0000);
        axr(OFS_RESULT);
        chk(rd[15:0], 16'h0000);
        axw(OFS_DIV, 16'h0003);
        axr(OFS_DIV);
        chk(rd[15:0], 16'h0003);
        axw(OFS_DIV, 16'h0000);
        axr(8'h18);
        chk({14'h0, rs}, {14'h0, RESP_SLVERR});
        axw(8'h18, 16'hffff);
        chk({14'h0, bs}, {14'h0, RESP_SLVERR});
    endtask : t_reset

    task automatic t_rmw;
        axr(OFS_CTRL_RMW);
        chk(rd[15:0] & 16'hc000, 16'hc000);
        axw(OFS_RESULT, 16'h0000);
        axw(OFS_CTRL_RMW, 16'h8001);
        axr(OFS_CTRL);
        chk(rd[15:0] & 16'hc000, 16'h8000);
        axw(OFS_CTRL_RMW, 16'h4001);
        axr(OFS_CTRL);
        chk(rd[15:0] & 16'hc000, 16'h0000);
    endtask : t_rmw

    task automatic t_ovf;
        int n;
        n = 0;
        axw(OFS_IRQ_MASK, 16'h0001);
        axw(OFS_RESULT, 16'hfff0);
        // reload timer, overflow enable, count end enable kept clear
        axw(OFS_CTRL, 16'h8401);
        while (pulse_level_indicator !== 1'b1) begin
            @(posedge aclk);
            n++;
            if (n > 200) over();
        end
        chk({15'h0, pulse_level_indicator}, 16'h0001);
        axw(OFS_CTRL, 16'h0401);
        axw(OFS_CTRL, 16'h4401);
        axr(OFS_CTRL);
        chk({15'h0, rd[B_PULSE_LEVEL_INDICATOR]}, 16'h0001);
        axw(OFS_IRQ_MASK, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        axw(OFS_IRQ_MASK, 16'h0001);
        chk({15'h0, irq}, 16'h0001);
        axr(OFS_IRQ_ST);
        chk(rd[15:0], 16'h0001);
        chk({15'h0, irq}, 16'h0000);
    endtask : t_ovf

    task automatic t_single;
        axw(OFS_RESULT, 16'h1234);
        axw(OFS_CTRL, 16'h9005);
        u_src.pulse(40, 10);
        axr(OFS_CTRL);
        chk(rd[15:0] & 16'h0800, 16'h0800);
        axr(OFS_RESULT);
        chk_rng(rd[15:0], 16'h0009, 16'h000b);
        axr(OFS_CTRL);
        chk(rd[15:0] & 16'h0800, 16'h0000);
        axr(OFS_IRQ_ST);
        chk(rd[15:0], 16'h0002);
    endtask : t_single

    task automatic t_cont;
        axw(OFS_CTRL, 16'h900c);
        repeat (3) u_src.pulse(8, 12);
        axr(OFS_CTRL);
        chk(rd[15:0] & 16'h2800, 16'h2800);
        axr(OFS_RESULT);
        chk_rng(rd[15:0], 16'h0004, 16'h0006);
        axr(OFS_CTRL);
        chk(rd[15:0] & 16'h2800, 16'h0000);
        axw(OFS_CTRL, 16'h400c);
    endtask : t_cont

    // divided period, divide by 4: start at a falling edge, end at the 4th one after
    task automatic t_div;
        axw(OFS_CTRL, 16'h9003);
        repeat (5) u_src.pulse(4, 4);
        axr(OFS_CTRL);
        chk(rd[15:0] & 16'h8800, 16'h0800);
        axr(OFS_RESULT);
        chk_rng(rd[15:0], 16'h0007, 16'h0009);
    endtask : t_div

    // =========================================================
    // clock and main sequence
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    initial begin
        fails = 0;
        checks_done = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, awprot, arprot, wdata} = '0;
        wstrb = 4'hf;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_rmw();
        t_ovf();
        t_single();
        t_cont();
        t_div();
        tally_and_finish();
    end
endmodule : test_pulse_width_counter_timer

bind pwc_timer pwc_props u_props (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .bready, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
